// ### src/pie_port_irq_map.vh
// Function
// - Enabled active condition with global enable interrupts.
// - Status bits set regardless of enable bits.
// - Enable bit layout mirrors status bit layout.
// - Bit 31 gates cold presence; else zero.
// - Bit 30 gates task file error.
// - Bit 29 gates host bus fatal error.
// - Bit 28 gates host bus data error.
// - Bit 27 gates link fatal error.
// - Bit 26 gates link non-fatal error.
// - Bit 24 gates receive overflow.
// - Bit 23 gates incorrect port multiplier.
// - Bit 22 gates phy ready change.
// - Bit 7 gates mechanical switch; else zero.
// - Bit 6 gates port connect change.
// - Bit 5 gates descriptor processed.
// - Bit 4 gates unknown frame received.
// - Bit 3 gates set device bits frame.
// - Bit 2 gates DMA setup frame.
// - Bit 1 gates PIO setup frame.
// - Bit 0 gates device-to-host register frame.
`ifndef PIE_PORT_IRQ_MAP_VH
`define PIE_PORT_IRQ_MAP_VH

// Register offsets in bytes.
`define PIE_OFS_STATUS 8'h10
`define PIE_OFS_ENABLE 8'h14
`define PIE_OFS_PENDING 8'h3c

// Bit positions shared by the status and enable registers.
`define PIE_BIT_COLD 31
`define PIE_BIT_TASKFILE 30
`define PIE_BIT_HB_FATAL 29
`define PIE_BIT_HB_DATA 28
`define PIE_BIT_LINK_FATAL 27
`define PIE_BIT_LINK_NONFATAL 26
`define PIE_BIT_OVERFLOW 24
`define PIE_BIT_BAD_MULT 23
`define PIE_BIT_PHY_READY 22
`define PIE_BIT_MECH 7
`define PIE_BIT_CONNECT 6
`define PIE_BIT_DESC_DONE 5
`define PIE_BIT_UNKNOWN 4
`define PIE_BIT_SET_DEV 3
`define PIE_BIT_DMA_SETUP 2
`define PIE_BIT_PIO_SETUP 1
`define PIE_BIT_D2H_REG 0

// Implemented bit positions; bit 25 and bits 21 to 8 are reserved.
`define PIE_IMPL_MASK 32'hfdc0_00ff
// Status bits that mirror a level held elsewhere instead of latching.
`define PIE_MIRROR_MASK 32'h0040_0050

// Reset values.
`define PIE_ENABLE_RESET 32'h0000_0000
`define PIE_STATUS_RESET 32'h0000_0000

`endif

// ### src/pie_flag_cell.v
`timescale 1ns/100ps
// One status flag with its set, clear and mirror behaviour.
module pie_flag_cell #(
    parameter PRESENT = 1'b1,
    parameter MIRROR = 1'b0
) (
    // Clock and reset.
    input wire core_clk,
    input wire rst,
    // Event side.
    input wire set_pulse,
    input wire mirror_level,
    // Software side.
    input wire clear_pulse,
    // Stored flag.
    output wire flag
);

    reg flag_reg;
    reg flag_next;

    // A set arriving with a clear wins, so no event is lost.
    always @* begin
        if (!PRESENT) begin
            flag_next = 1'b0;
        end else if (MIRROR) begin
            flag_next = mirror_level;
        end else if (set_pulse) begin
            flag_next = 1'b1;
        end else if (clear_pulse) begin
            flag_next = 1'b0;
        end else begin
            flag_next = flag_reg;
        end
    end

    // The flag register itself.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;

endmodule

// ### src/pie_port_irq.v
// Strobed register access is this design's own decision.
`timescale 1ns/100ps
`include "pie_port_irq_map.vh"
// Per-port interrupt status, enable and request logic.
module pie_port_irq #(
    parameter HAS_COLD_PRESENCE = 1'b1,
    parameter HAS_MECH_SWITCH = 1'b1
) (
    // Clock and reset.
    input wire core_clk,
    input wire rst,
    // Register port.
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [31:0] reg_rdata,
    // Event sources, one-cycle pulses per status bit.
    input wire [31:0] flag_set,
    // Levels that mirrored status bits follow.
    input wire [31:0] flag_mirror,
    // Global enable from the adapter control logic.
    input wire global_irq_enable,
    // Interrupt request to the aggregation logic.
    output wire port_irq
);

    // Bits that exist in this build, after the optional sources.
    localparam [31:0] IMPL_MASK = `PIE_IMPL_MASK
        & ~({31'h0000_0000, ~HAS_COLD_PRESENCE} << `PIE_BIT_COLD)
        & ~({31'h0000_0000, ~HAS_MECH_SWITCH} << `PIE_BIT_MECH);
    localparam [31:0] MIRROR_MASK = `PIE_MIRROR_MASK;

    reg [31:0] port_irq_enable_reg;
    reg [31:0] port_irq_enable_next;
    reg [31:0] rdata_reg;
    reg [31:0] rdata_next;
    reg irq_reg;
    wire irq_next;
    wire [31:0] port_irq_status_reg;
    wire [31:0] status_clear;
    wire [31:0] pending;
    wire hit_status;
    wire hit_enable;
    wire hit_pending;

    // Address decode of the three registers.
    assign hit_status = (reg_addr == `PIE_OFS_STATUS);
    assign hit_enable = (reg_addr == `PIE_OFS_ENABLE);
    assign hit_pending = (reg_addr == `PIE_OFS_PENDING);

    // Only implemented bits take a write; reserved ones stay zero.
    always @* begin
        port_irq_enable_next = port_irq_enable_reg;
        if (reg_wr && hit_enable) begin
            port_irq_enable_next = reg_wdata & IMPL_MASK;
        end
    end

    // Enable register starts with every source masked.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            port_irq_enable_reg <= `PIE_ENABLE_RESET;
        end else begin
            port_irq_enable_reg <= port_irq_enable_next;
        end
    end

    // Writing ones to the status register clears latched flags.
    assign status_clear = (reg_wr && hit_status) ?
        (reg_wdata & ~MIRROR_MASK) : 32'h0000_0000;

    // One flag cell per status bit, at the same place as its enable.
    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1) begin : g_flag
            pie_flag_cell #(
                .PRESENT(IMPL_MASK[i]),
                .MIRROR(MIRROR_MASK[i])
            ) u_cell (
                .core_clk(core_clk),
                .rst(rst),
                .set_pulse(flag_set[i]),
                .mirror_level(flag_mirror[i]),
                .clear_pulse(status_clear[i]),
                .flag(port_irq_status_reg[i])
            );
        end
    endgenerate

    // Named enables, taken from the enable register.
    wire cold_presence_irq_en;
    wire taskfile_err_irq_en;
    wire hostbus_fatal_irq_en;
    wire hostbus_data_err_irq_en;
    wire link_fatal_irq_en;
    wire link_nonfatal_irq_en;

    // Link and port change events.
    wire overflow_irq_en;
    wire bad_multiplier_irq_en;
    wire phy_ready_change_irq_en;
    wire mech_switch_irq_en;
    wire connect_change_irq_en;

    // Frame and transfer events.
    wire descriptor_done_irq_en;
    wire unknown_frame_irq_en;
    wire set_dev_bits_irq_en;
    wire dma_setup_irq_en;
    wire pio_setup_irq_en;
    wire d2h_reg_irq_en;

    // Enable bits sit where their status bits sit.
    assign cold_presence_irq_en = port_irq_enable_reg[`PIE_BIT_COLD];
    assign taskfile_err_irq_en = port_irq_enable_reg[`PIE_BIT_TASKFILE];
    assign hostbus_fatal_irq_en = port_irq_enable_reg[`PIE_BIT_HB_FATAL];
    assign hostbus_data_err_irq_en = port_irq_enable_reg[`PIE_BIT_HB_DATA];
    assign link_fatal_irq_en = port_irq_enable_reg[`PIE_BIT_LINK_FATAL];
    assign link_nonfatal_irq_en =
        port_irq_enable_reg[`PIE_BIT_LINK_NONFATAL];

    // Enables of the link and port change events.
    assign overflow_irq_en = port_irq_enable_reg[`PIE_BIT_OVERFLOW];
    assign bad_multiplier_irq_en = port_irq_enable_reg[`PIE_BIT_BAD_MULT];
    assign phy_ready_change_irq_en =
        port_irq_enable_reg[`PIE_BIT_PHY_READY];
    assign mech_switch_irq_en = port_irq_enable_reg[`PIE_BIT_MECH];
    assign connect_change_irq_en = port_irq_enable_reg[`PIE_BIT_CONNECT];

    // Enables of the frame and transfer events.
    assign descriptor_done_irq_en =
        port_irq_enable_reg[`PIE_BIT_DESC_DONE];
    assign unknown_frame_irq_en = port_irq_enable_reg[`PIE_BIT_UNKNOWN];
    assign set_dev_bits_irq_en = port_irq_enable_reg[`PIE_BIT_SET_DEV];
    assign dma_setup_irq_en = port_irq_enable_reg[`PIE_BIT_DMA_SETUP];
    assign pio_setup_irq_en = port_irq_enable_reg[`PIE_BIT_PIO_SETUP];
    assign d2h_reg_irq_en = port_irq_enable_reg[`PIE_BIT_D2H_REG];

    // Named status flags, taken from the flag cells.
    wire cold_presence_flag;
    wire taskfile_err_flag;
    wire hostbus_fatal_flag;
    wire hostbus_data_err_flag;
    wire link_fatal_flag;
    wire link_nonfatal_flag;

    // Link and port change flags.
    wire overflow_flag;
    wire bad_multiplier_flag;
    wire phy_ready_change_flag;
    wire mech_switch_flag;
    wire connect_change_flag;

    // Frame and transfer flags.
    wire descriptor_done_flag;
    wire unknown_frame_flag;
    wire set_dev_bits_flag;
    wire dma_setup_flag;
    wire pio_setup_flag;
    wire d2h_reg_flag;

    // Status flags by source.
    assign cold_presence_flag = port_irq_status_reg[`PIE_BIT_COLD];
    assign taskfile_err_flag = port_irq_status_reg[`PIE_BIT_TASKFILE];
    assign hostbus_fatal_flag = port_irq_status_reg[`PIE_BIT_HB_FATAL];
    assign hostbus_data_err_flag = port_irq_status_reg[`PIE_BIT_HB_DATA];
    assign link_fatal_flag = port_irq_status_reg[`PIE_BIT_LINK_FATAL];
    assign link_nonfatal_flag =
        port_irq_status_reg[`PIE_BIT_LINK_NONFATAL];

    // Flags of the link and port change events.
    assign overflow_flag = port_irq_status_reg[`PIE_BIT_OVERFLOW];
    assign bad_multiplier_flag = port_irq_status_reg[`PIE_BIT_BAD_MULT];
    assign phy_ready_change_flag = port_irq_status_reg[`PIE_BIT_PHY_READY];
    assign mech_switch_flag = port_irq_status_reg[`PIE_BIT_MECH];
    assign connect_change_flag = port_irq_status_reg[`PIE_BIT_CONNECT];

    // Flags of the frame and transfer events.
    assign descriptor_done_flag = port_irq_status_reg[`PIE_BIT_DESC_DONE];
    assign unknown_frame_flag = port_irq_status_reg[`PIE_BIT_UNKNOWN];
    assign set_dev_bits_flag = port_irq_status_reg[`PIE_BIT_SET_DEV];
    assign dma_setup_flag = port_irq_status_reg[`PIE_BIT_DMA_SETUP];
    assign pio_setup_flag = port_irq_status_reg[`PIE_BIT_PIO_SETUP];
    assign d2h_reg_flag = port_irq_status_reg[`PIE_BIT_D2H_REG];

    // Gated terms: enable, flag and global enable must all be high.
    wire cold_presence_irq;
    wire taskfile_err_irq;
    wire hostbus_fatal_irq;
    wire hostbus_data_err_irq;
    wire link_fatal_irq;
    wire link_nonfatal_irq;

    // Gated link and port change events.
    wire overflow_irq;
    wire bad_multiplier_irq;
    wire phy_ready_change_irq;
    wire mech_switch_irq;
    wire connect_change_irq;

    // Gated frame and transfer events.
    wire descriptor_done_irq;
    wire unknown_frame_irq;
    wire set_dev_bits_irq;
    wire dma_setup_irq;
    wire pio_setup_irq;
    wire d2h_reg_irq;

    // Each source is masked by its own enable and by the global one.
    // A device showed up on a port that was powered down.
    assign cold_presence_irq =
        cold_presence_irq_en & cold_presence_flag & global_irq_enable;

    // The attached device reported an error in its status.
    assign taskfile_err_irq =
        taskfile_err_irq_en & taskfile_err_flag & global_irq_enable;

    // A fatal error on the host bus stopped a transfer.
    assign hostbus_fatal_irq =
        hostbus_fatal_irq_en & hostbus_fatal_flag & global_irq_enable;

    // A data error was seen while moving data over the host bus.
    assign hostbus_data_err_irq = hostbus_data_err_irq_en
        & hostbus_data_err_flag & global_irq_enable;

    // An error on the serial link that the port could not survive.
    assign link_fatal_irq =
        link_fatal_irq_en & link_fatal_flag & global_irq_enable;

    // An error on the serial link that the port worked through.
    assign link_nonfatal_irq =
        link_nonfatal_irq_en & link_nonfatal_flag & global_irq_enable;

    // More bytes came in than the command had room for.
    assign overflow_irq =
        overflow_irq_en & overflow_flag & global_irq_enable;

    // A frame came from a device that had no command outstanding.
    assign bad_multiplier_irq = bad_multiplier_irq_en
        & bad_multiplier_flag & global_irq_enable;

    // The physical layer ready state changed; this flag is mirrored.
    assign phy_ready_change_irq = phy_ready_change_irq_en
        & phy_ready_change_flag & global_irq_enable;

    // The mechanical presence switch was opened or closed.
    assign mech_switch_irq =
        mech_switch_irq_en & mech_switch_flag & global_irq_enable;

    // The connect state of the port changed; this flag is mirrored.
    assign connect_change_irq = connect_change_irq_en
        & connect_change_flag & global_irq_enable;

    // A descriptor marked for notice has moved all of its data.
    assign descriptor_done_irq = descriptor_done_irq_en
        & descriptor_done_flag & global_irq_enable;

    // An unknown frame was stored to memory; this flag is mirrored.
    assign unknown_frame_irq = unknown_frame_irq_en
        & unknown_frame_flag & global_irq_enable;

    // A set device bits frame was stored to memory.
    assign set_dev_bits_irq =
        set_dev_bits_irq_en & set_dev_bits_flag & global_irq_enable;

    // A DMA setup frame was stored to memory.
    assign dma_setup_irq =
        dma_setup_irq_en & dma_setup_flag & global_irq_enable;

    // A PIO setup frame was stored and its data were moved.
    assign pio_setup_irq =
        pio_setup_irq_en & pio_setup_flag & global_irq_enable;

    // A device-to-host register frame was stored to memory.
    assign d2h_reg_irq =
        d2h_reg_irq_en & d2h_reg_flag & global_irq_enable;

    // Gated terms gathered back into the shared bit layout.
    assign pending = {
        // Error sources, bits 31 to 26.
        cold_presence_irq,
        taskfile_err_irq,
        hostbus_fatal_irq,
        hostbus_data_err_irq,
        link_fatal_irq,
        link_nonfatal_irq,
        // Reserved bit 25, then the link events in bits 24 to 22.
        1'b0,
        overflow_irq,
        bad_multiplier_irq,
        phy_ready_change_irq,
        // Reserved bits 21 to 8.
        14'h0000,
        // Frame and change events, bits 7 to 0.
        mech_switch_irq,
        connect_change_irq,
        descriptor_done_irq,
        unknown_frame_irq,
        set_dev_bits_irq,
        dma_setup_irq,
        pio_setup_irq,
        d2h_reg_irq
    };

    // Any gated term raises the request; none left drops it.
    assign irq_next = |pending;

    // The request leaves through a flip-flop, one cycle after its cause.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    // Read data for the addressed register; unmapped reads give zero.
    always @* begin
        rdata_next = 32'h0000_0000;
        if (reg_rd) begin
            if (hit_status) begin
                rdata_next = port_irq_status_reg;
            end else if (hit_enable) begin
                rdata_next = port_irq_enable_reg & IMPL_MASK;
            end else if (hit_pending) begin
                rdata_next = pending;
            end
        end
    end

    // Read data stand only in the cycle after the read strobe.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign port_irq = irq_reg;

endmodule

// ### tb/pie_port_irq_props.sv
`timescale 1ns/100ps
`include "pie_port_irq_map.vh"
// Port-level checks on the register port and the interrupt request.
module pie_port_irq_props (
    // Clock and reset.
    input wire core_clk,
    input wire rst,
    // Register port.
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    // Events and request.
    input wire [31:0] flag_set,
    input wire [31:0] flag_mirror,
    input wire global_irq_enable,
    input wire port_irq
);
    localparam [31:0] IMPL = `PIE_IMPL_MASK;
    localparam [31:0] MIRR = `PIE_MIRROR_MASK;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Read data stand only in the cycle after a read strobe.
    a_rdata_idle: assert property (!$past(reg_rd) |->
        reg_rdata == 32'h0)
        else $error("read data not zero outside a read");
    a_unmapped_read: assert property ($past(reg_rd) &&
        !($past(reg_addr) inside {8'h10, 8'h14, 8'h3c})
        |-> reg_rdata == 32'h0)
        else $error("unmapped read returned data");
    a_rsvd_enable: assert property (
        $past(reg_rd && reg_addr == 8'h14)
        |-> (reg_rdata & ~IMPL) == 32'h0)
        else $error("reserved enable bit read as one");
    a_rsvd_status: assert property (
        $past(reg_rd && reg_addr == 8'h10)
        |-> (reg_rdata & ~IMPL) == 32'h0)
        else $error("reserved status bit read as one");
    a_enable_readback: assert property (
        $past(reg_wr && reg_addr == 8'h14, 2)
        && $past(reg_rd && reg_addr == 8'h14)
        |-> reg_rdata == ($past(reg_wdata, 2) & IMPL))
        else $error("enable readback differs from write");
    a_mirror_follows: assert property (
        $past(reg_rd && reg_addr == 8'h10)
        |-> (reg_rdata & MIRR) == ($past(flag_mirror, 2) & MIRR))
        else $error("mirrored status differs from its level");
    a_set_recorded: assert property (
        $past(reg_rd && reg_addr == 8'h10)
        |-> ($past(flag_set, 2) & IMPL & ~MIRR & ~reg_rdata) == 32'h0)
        else $error("set pulse not recorded in status");
    a_pending_link: assert property (
        $past(reg_rd && reg_addr == 8'h3c)
        |-> (reg_rdata != 32'h0) == port_irq)
        else $error("request disagrees with pending bits");
    a_no_global: assert property (
        !$past(global_irq_enable) |-> !port_irq)
        else $error("request raised without global enable");
    c_irq: cover property ($rose(port_irq));
    c_readback: cover property (reg_wr && reg_addr == 8'h14 ##1 reg_rd);
    c_pending: cover property (reg_rd && reg_addr == 8'h3c ##1 port_irq);
endmodule

bind pie_port_irq pie_port_irq_props u_props (.core_clk(core_clk),
    .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flag_set(flag_set), .flag_mirror(flag_mirror),
    .global_irq_enable(global_irq_enable), .port_irq(port_irq));

// ### tb/pie_port_irq_bench.sv
`timescale 1ns/100ps
`include "pie_port_irq_map.vh"
// Self-checking bench for the port interrupt gating block.
module pie_port_irq_bench;
    localparam [31:0] IMPL = `PIE_IMPL_MASK;
    localparam [31:0] MIRR = `PIE_MIRROR_MASK;
    logic core_clk, rst, reg_wr, reg_rd, global_irq_enable, port_irq;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, flag_set, flag_mirror, d, e, s, mr;
    logic g;
    logic [31:0] st;
    int n_fail, n_compared;
    int bits[17] = '{31, 30, 29, 28, 27, 26, 24, 23, 22, 7, 6, 5, 4, 3, 2,
        1, 0};

    pie_port_irq dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .flag_set(flag_set),
        .flag_mirror(flag_mirror), .global_irq_enable(global_irq_enable),
        .port_irq(port_irq));

    // Free-running 100 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Expected request from status, enable and global enable.
    function automatic logic exp_irq(logic [31:0] st, logic [31:0] en,
        logic gl);
        return gl & (|(st & en & IMPL));
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Bus cycles are entered just after a rising edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge core_clk);
    endtask

    // Raises or removes the source of one status bit.
    // The request shows the change two edges after the call starts.
    task automatic src(input int b, input logic on);
        if (MIRR[b]) begin
            flag_mirror[b] <= on;
            @(posedge core_clk);
        end else if (on) begin
            flag_set[b] <= 1'b1;
            @(posedge core_clk);
            flag_set[b] <= 1'b0;
        end else begin
            wr(`PIE_OFS_STATUS, 32'h1 << b);
        end
        @(posedge core_clk);
    endtask

    // Checks the request in the current cycle, then waits one edge.
    task automatic irq_is(input logic v);
        #1 chk("port_irq", {31'h0, port_irq}, {31'h0, v});
        @(posedge core_clk);
    endtask

    // Cuts a hang short.
    initial begin
        #200000;
        n_fail++;
        tally_and_finish();
    end

    initial begin
        {reg_wr, reg_rd, global_irq_enable} = 3'b000;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        {flag_set, flag_mirror} = 64'h0;
        rst = 1'b1;
        void'($urandom(73));
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        rd(8'h14, d); chk("enable reset", d, 32'h0000_0000);
        rd(8'h3c, d); chk("pending reset", d, 32'h0000_0000);
        wr(8'h14, 32'hffff_ffff);
        rd(8'h14, d); chk("enable ones", d, IMPL);
        wr(8'h20, 32'h0000_0000);
        rd(8'h20, d); chk("unmapped", d, 32'h0000_0000);
        rd(8'h14, d); chk("enable kept", d, IMPL);
        for (int i = 0; i < 8; i++) begin
            e = $urandom;
            wr(8'h14, e);
            rd(8'h14, d); chk("enable rand", d, e & IMPL);
        end
        // Each source alone: gate, record, global, clear.
        @(posedge core_clk);
        global_irq_enable <= 1'b1;
        foreach (bits[i]) begin
            wr(8'h14, 32'h1 << bits[i]);
            src(bits[i], 1'b1);
            irq_is(1'b1);
            wr(8'h14, 32'h0000_0000);
            @(posedge core_clk);
            irq_is(1'b0);
            rd(8'h10, d);
            chk("status kept", d, 32'h1 << bits[i]);
            wr(8'h14, 32'h1 << bits[i]);
            @(posedge core_clk);
            irq_is(1'b1);
            global_irq_enable <= 1'b0;
            @(posedge core_clk);
            irq_is(1'b0);
            global_irq_enable <= 1'b1;
            src(bits[i], 1'b0);
            @(posedge core_clk);
            irq_is(1'b0);
        end
        // Random mix of enables, events, levels and global enable.
        for (int i = 0; i < 40; i++) begin
            e = $urandom;
            s = $urandom;
            mr = $urandom;
            g = $urandom;
            wr(8'h14, e);
            flag_set <= s;
            flag_mirror <= mr;
            global_irq_enable <= g;
            @(posedge core_clk);
            flag_set <= 32'h0000_0000;
            st = (s & ~MIRR & IMPL) | (mr & MIRR);
            rd(8'h10, d);
            chk("status set", d, st);
            irq_is(exp_irq(st, e, g));
            rd(8'h3c, d);
            chk("pending", d, st & e & IMPL & {32{g}});
            wr(8'h10, 32'hffff_ffff);
            rd(8'h10, d); chk("status w1c", d, mr & MIRR);
            flag_mirror <= 32'h0000_0000;
            @(posedge core_clk);
        end
        tally_and_finish();
    end
endmodule
